// File: timer16_pkg.sv
package timer16_pkg;
    // ****************************************
    // Bus locations of the byte registers
    // ****************************************
    localparam logic [2:0] ADDR_COUNT_LOW = 3'h0;
    localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
    localparam logic [2:0] ADDR_CAPTURE_LOW = 3'h2;
    localparam logic [2:0] ADDR_CAPTURE_HIGH = 3'h3;
    localparam logic [2:0] ADDR_COMPARE_A_LOW = 3'h4;
    localparam logic [2:0] ADDR_COMPARE_A_HIGH = 3'h5;
    localparam logic [2:0] ADDR_COMPARE_B_LOW = 3'h6;
    localparam logic [2:0] ADDR_COMPARE_B_HIGH = 3'h7;
    // ****************************************
    // Mode encodings and fixed values
    // ****************************************
    localparam logic [3:0] WAVE_NORMAL = 4'h0;
    localparam logic [3:0] WAVE_CTC_COMPARE = 4'h4;
    localparam logic [3:0] WAVE_PWM_CAPTURE_TOP_A = 4'h8;
    localparam logic [3:0] WAVE_PWM_CAPTURE_TOP_B = 4'ha;
    localparam logic [3:0] WAVE_CTC_CAPTURE = 4'hc;
    localparam logic [3:0] WAVE_FAST_CAPTURE = 4'he;
    localparam logic [2:0] CLOCK_STOPPED = 3'h0;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam int FILTER_SAMPLES = 4;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage : timer16_pkg

// File: capture_filter.sv
`timescale 1ns/100ps
module capture_filter
    import timer16_pkg::*;
#(
    parameter int SAMPLES = FILTER_SAMPLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_sample,
    output logic o_level
);
    logic [SAMPLES-1:0] history;

    // Sampled every system clock, never by the prescaler
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            history <= '0;
        end else begin
            history <= {history[SAMPLES-2:0], i_sample};
        end
    end

    // Output moves only when all samples agree; with the filter disabled it follows the sample
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_level <= 1'b0;
        end else if (!i_enable) begin
            o_level <= i_sample;
        end else if (&history) begin
            o_level <= 1'b1;
        end else if (~|history) begin
            o_level <= 1'b0;
        end
    end

    a_filter_agree: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_enable && $changed(o_level)) |-> ($past(history) == {SAMPLES{o_level}}))
        else $error("filter output changed without agreeing samples");
endmodule : capture_filter

// File: timer16_counter_capture.sv
`timescale 1ns/100ps
// Behaviour
// - High-byte writes and count/capture high-byte reads use shared staging register
// - Low-byte read/write moves staging with upper byte
// - Each tick clears, increments or decrements counter
// - Clock select field picks tick source
// - Select zero stops counting
// - Counter accessible with or without ticks
// - CPU write beats clear and count
// - Overflow flag set per mode, requests interrupt
// - Matching edge on pin/comparator triggers capture
// - Capture copies counter, sets flag same cycle
// - Enabled capture flag interrupts; acknowledge or one clears
// - Capture low read stages high byte
// - Capture writable only in capture-top modes
// - Select bit switches source to comparator
// - Detector idle in capture-top modes; filter keeps sampling
// - Filter changes after four agreeing samples
// - Filter enable adds four cycles delay
// - Filter samples on system clock
// - Staging register holds between high writes and count/capture low reads
// - Capture follows driven pin value
// - Compare reads bypass staging register
module timer16_counter_capture
    import timer16_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [2:0] i_addr,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic [2:0] i_clock_select_field,
    input wire logic [3:0] i_wave_mode_field,
    input wire logic i_prescale_tick,
    input wire logic i_external_tick,
    input wire logic i_filter_enable,
    input wire logic i_capture_rising,
    input wire logic i_comparator_capture_select,
    input wire logic i_capture_pin,
    input wire logic i_comparator_output,
    input wire logic i_capture_irq_enable,
    input wire logic i_overflow_irq_enable,
    input wire logic i_capture_flag_clear,
    input wire logic i_overflow_flag_clear,
    input wire logic i_capture_irq_ack,
    input wire logic i_overflow_irq_ack,
    output logic [WIDTH-1:0] o_count_value,
    output logic [WIDTH-1:0] o_capture_value,
    output logic o_capture_flag,
    output logic o_overflow_flag,
    output logic o_capture_irq,
    output logic o_overflow_irq
);
    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [2:0] {
        DIR_UP = 3'b001,
        DIR_DOWN = 3'b010,
        DIR_HOLD = 3'b100
    } direction_t;

    direction_t direction;
    logic [7:0] staging;
    logic [WIDTH-1:0] compare_a;
    logic [WIDTH-1:0] compare_b;
    logic [WIDTH-1:0] top_value;
    logic [WIDTH-1:0] next_count;
    logic timer_tick;
    logic capture_top_mode;
    logic phase_correct;
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic sync_d;
    logic source_level;
    logic filtered;
    logic filtered_last;
    logic capture_event;
    logic count_wr;
    logic overflow_event;

    function automatic logic is_capture_top(input logic [3:0] mode);
        return mode == WAVE_PWM_CAPTURE_TOP_A || mode == WAVE_PWM_CAPTURE_TOP_B
            || mode == WAVE_CTC_CAPTURE || mode == WAVE_FAST_CAPTURE;
    endfunction : is_capture_top

    assign capture_top_mode = is_capture_top(i_wave_mode_field);
    assign phase_correct = (i_wave_mode_field == WAVE_PWM_CAPTURE_TOP_A)
        || (i_wave_mode_field == WAVE_PWM_CAPTURE_TOP_B);
    assign count_wr = i_write && (i_addr == ADDR_COUNT_LOW);

    // ****************************************
    // Tick selection
    // ****************************************
    always_comb begin
        unique case (i_clock_select_field)
            CLOCK_STOPPED: timer_tick = 1'b0;
            3'h6, 3'h7: timer_tick = i_external_tick;
            default: timer_tick = i_prescale_tick;
        endcase
    end

    always_comb begin
        if (capture_top_mode) begin
            top_value = o_capture_value;
        end else if (i_wave_mode_field == WAVE_CTC_COMPARE) begin
            top_value = compare_a;
        end else begin
            top_value = COUNT_MAX;
        end
    end

    // ****************************************
    // Counter
    // ****************************************
    always_comb begin
        next_count = o_count_value;
        overflow_event = 1'b0;
        if (timer_tick) begin
            if (phase_correct) begin
                if (direction == DIR_DOWN) begin
                    next_count = o_count_value - 1'b1;
                    overflow_event = (o_count_value == COUNT_BOTTOM + 1'b1);
                end else begin
                    next_count = o_count_value + 1'b1;
                end
            end else if (o_count_value == top_value) begin
                next_count = COUNT_BOTTOM;
                overflow_event = (top_value == COUNT_MAX)
                    || (i_wave_mode_field == WAVE_FAST_CAPTURE);
            end else begin
                next_count = o_count_value + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_count_value <= WORD_RESET;
        end else if (count_wr) begin
            o_count_value <= {staging, i_wdata};
        end else begin
            o_count_value <= next_count;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || !phase_correct) begin
            direction <= DIR_UP;
        end else if (timer_tick && !count_wr) begin
            if (direction != DIR_DOWN && o_count_value + 1'b1 == top_value) begin
                direction <= DIR_DOWN;
            end else if (direction == DIR_DOWN && o_count_value == COUNT_BOTTOM + 1'b1) begin
                direction <= DIR_UP;
            end
        end
    end

    // ****************************************
    // Staging register and byte access
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            staging <= BYTE_RESET;
        end else if (i_write && i_addr[0]) begin
            staging <= i_wdata;
        end else if (i_read && i_addr == ADDR_COUNT_LOW) begin
            staging <= o_count_value[15:8];
        end else if (i_read && i_addr == ADDR_CAPTURE_LOW) begin
            staging <= o_capture_value[15:8];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            compare_a <= WORD_RESET;
            compare_b <= WORD_RESET;
        end else if (i_write && i_addr == ADDR_COMPARE_A_LOW) begin
            compare_a <= {staging, i_wdata};
        end else if (i_write && i_addr == ADDR_COMPARE_B_LOW) begin
            compare_b <= {staging, i_wdata};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= BYTE_RESET;
        end else if (i_read) begin
            unique case (i_addr)
                ADDR_COUNT_LOW: o_rdata <= o_count_value[7:0];
                ADDR_CAPTURE_LOW: o_rdata <= o_capture_value[7:0];
                ADDR_COMPARE_A_LOW: o_rdata <= compare_a[7:0];
                ADDR_COMPARE_A_HIGH: o_rdata <= compare_a[15:8];
                ADDR_COMPARE_B_LOW: o_rdata <= compare_b[7:0];
                ADDR_COMPARE_B_HIGH: o_rdata <= compare_b[15:8];
                default: o_rdata <= staging;
            endcase
        end
    end

    // ****************************************
    // Capture input path
    // ****************************************
    // Pin is the driven port value, so software can toggle it
    assign source_level = i_comparator_capture_select
        ? sync_d : sync_b;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sync_a <= i_capture_pin;
            sync_b <= sync_a;
            sync_c <= i_comparator_output;
            sync_d <= sync_c;
        end
    end

    capture_filter #(
        .SAMPLES(FILTER_SAMPLES)
    ) u_filter (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_enable(i_filter_enable),
        .i_sample(source_level),
        .o_level(filtered)
    );

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            filtered_last <= 1'b0;
        end else begin
            filtered_last <= filtered;
        end
    end

    assign capture_event = !capture_top_mode
        && (filtered != filtered_last)
        && (filtered == i_capture_rising);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_capture_value <= WORD_RESET;
        end else if (capture_event) begin
            o_capture_value <= o_count_value;
        end else if (i_write && i_addr == ADDR_CAPTURE_LOW && capture_top_mode) begin
            o_capture_value <= {staging, i_wdata};
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_capture_flag <= 1'b0;
        end else if (capture_event) begin
            o_capture_flag <= 1'b1;
        end else if (i_capture_flag_clear || i_capture_irq_ack) begin
            o_capture_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_overflow_flag <= 1'b0;
        end else if (overflow_event && !count_wr) begin
            o_overflow_flag <= 1'b1;
        end else if (i_overflow_flag_clear || i_overflow_irq_ack) begin
            o_overflow_flag <= 1'b0;
        end
    end

    assign o_capture_irq = o_capture_flag && i_capture_irq_enable;
    assign o_overflow_irq = o_overflow_flag && i_overflow_irq_enable;

    // ****************************************
    // Checks
    // ****************************************
    a_stop_holds: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_clock_select_field == CLOCK_STOPPED && !count_wr) ##1 1'b1
        |-> $stable(o_count_value))
        else $error("counter moved while stopped");
    a_write_wins: assert property (@(posedge i_clk) disable iff (i_reset)
        count_wr |=> o_count_value == {$past(staging), $past(i_wdata)})
        else $error("counter write lost");
    a_capture_copy: assert property (@(posedge i_clk) disable iff (i_reset)
        capture_event |=> o_capture_flag && o_capture_value == $past(o_count_value))
        else $error("capture copy or flag wrong");
    a_stage_count: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == ADDR_COUNT_LOW && !i_write)
        |=> staging == $past(o_count_value[15:8]))
        else $error("staging not loaded from counter");
    a_stage_capture: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == ADDR_CAPTURE_LOW && !i_write) ##1 !(i_read || i_write)
        ##1 (i_read && i_addr == ADDR_CAPTURE_HIGH)
        |=> o_rdata == $past(o_capture_value[15:8], 3))
        else $error("capture high byte read wrong");
    a_stage_holds: assert property (@(posedge i_clk) disable iff (i_reset)
        !(i_write && i_addr[0]) && !(i_read && !i_addr[2] && !i_addr[0]) |=> $stable(staging))
        else $error("staging changed unexpectedly");
    a_capture_guard: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_write && i_addr == ADDR_CAPTURE_LOW && !capture_top_mode && !capture_event)
        |=> $stable(o_capture_value))
        else $error("capture written in wrong mode");
    a_quiet_top: assert property (@(posedge i_clk) disable iff (i_reset)
        (capture_top_mode && !(i_write && i_addr == ADDR_CAPTURE_LOW))
        |=> $stable(o_capture_value) && !$rose(o_capture_flag))
        else $error("capture in capture-top mode");
    a_capture_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        ((i_capture_flag_clear || i_capture_irq_ack) && !capture_event)
        |=> !o_capture_flag && !o_capture_irq)
        else $error("capture flag or interrupt not cleared");
    a_compare_read: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == ADDR_COMPARE_A_HIGH && !i_write)
        |=> o_rdata == $past(compare_a[15:8]))
        else $error("compare high read used staging");

    c_capture: cover property (@(posedge i_clk) disable iff (i_reset) capture_event);
    c_overflow: cover property (@(posedge i_clk) disable iff (i_reset) overflow_event);
    c_word_read: cover property (@(posedge i_clk) disable iff (i_reset)
        (i_read && i_addr == ADDR_COUNT_LOW) ##2 (i_read && i_addr == ADDR_COUNT_HIGH));
    c_down: cover property (@(posedge i_clk) disable iff (i_reset) direction == DIR_DOWN);
endmodule : timer16_counter_capture

// File: cpu_bus_model.sv
`timescale 1ns/100ps
// ********
// Byte bus master standing in for the CPU core
// ********
module cpu_bus_model
    import timer16_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [2:0] o_addr,
    output logic o_read,
    output logic o_write,
    output logic [7:0] o_wdata
);
    initial begin
        o_addr = ADDR_COUNT_LOW;
        o_read = 1'b0;
        o_write = 1'b0;
        o_wdata = BYTE_RESET;
    end
    task automatic write_byte(input logic [2:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_addr <= addr;
        o_wdata <= data;
        o_write <= 1'b1;
        @(posedge i_clk);
        o_write <= 1'b0;
        // Released data lines show the inverse, not the last value
        o_wdata <= ~data;
        #1;
    endtask : write_byte
    task automatic read_byte(input logic [2:0] addr, output logic [7:0] data);
        @(posedge i_clk);
        o_addr <= addr;
        o_read <= 1'b1;
        @(posedge i_clk);
        o_read <= 1'b0;
        #1;
        data = i_rdata;
    endtask : read_byte
    // Whole two-byte accesses only, never interleaved with another
    task automatic write_word(input logic [2:0] addr, input logic [15:0] value);
        write_byte(addr + 3'h1, value[15:8]);
        write_byte(addr, value[7:0]);
    endtask : write_word
    task automatic read_word(input logic [2:0] addr, output logic [15:0] value);
        logic [7:0] low, high;
        read_byte(addr, low);
        read_byte(addr + 3'h1, high);
        value = {high, low};
    endtask : read_word
endmodule : cpu_bus_model

// File: tb_timer16_counter_capture.sv
`timescale 1ns/100ps
module tb_timer16_counter_capture
    import timer16_pkg::*;
;
    logic clk, reset, rd, wr, psc, ext, filt, rise, csel, pin, cmp;
    logic cie, oie, cclr, oclr, cack, oack, cflag, oflag, cirq, oirq;
    logic [2:0] addr, cs;
    logic [3:0] wave;
    logic [7:0] wdata, rdata, b;
    logic [15:0] count, cap, w, c;
    int n_mismatch, n_tests, n, d0, d1;
    timer16_counter_capture DUT (.i_clk(clk), .i_reset(reset), .i_addr(addr), .i_read(rd),
        .i_write(wr), .i_wdata(wdata), .o_rdata(rdata), .i_clock_select_field(cs),
        .i_wave_mode_field(wave), .i_prescale_tick(psc), .i_external_tick(ext),
        .i_filter_enable(filt), .i_capture_rising(rise), .i_comparator_capture_select(csel),
        .i_capture_pin(pin), .i_comparator_output(cmp), .i_capture_irq_enable(cie),
        .i_overflow_irq_enable(oie), .i_capture_flag_clear(cclr), .i_overflow_flag_clear(oclr),
        .i_capture_irq_ack(cack), .i_overflow_irq_ack(oack), .o_count_value(count),
        .o_capture_value(cap), .o_capture_flag(cflag), .o_overflow_flag(oflag),
        .o_capture_irq(cirq), .o_overflow_irq(oirq));
    cpu_bus_model cpu (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_read(rd),
        .o_write(wr), .o_wdata(wdata));
    always #10 clk = ~clk;
    // ********
    // Shared helpers
    // ********
    task automatic close_out;
        $display("Mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // 0 flag clear, 1 capture ack, 2 overflow clear, 3 overflow ack, 4 prescale, 5 external
    task automatic strobe(input int which);
        @(posedge clk);
        case (which)
            0: cclr <= 1'b1;
            1: cack <= 1'b1;
            2: oclr <= 1'b1;
            3: oack <= 1'b1;
            4: psc <= 1'b1;
            default: ext <= 1'b1;
        endcase
        @(posedge clk);
        {cclr, cack, oclr, oack, psc, ext} <= 6'h00;
        #1;
    endtask : strobe
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : idle
    task automatic pin_to(input logic v);
        @(posedge clk);
        pin <= v;
    endtask : pin_to
    task automatic wait_flag(input int max, output int k);
        k = 0;
        while (cflag !== 1'b1 && k < max) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (cflag !== 1'b1) begin
            n_mismatch++;
            close_out;
        end
    endtask : wait_flag
    // ********
    // Scenarios
    // ********
    task automatic t_stopped;
        cpu.write_word(ADDR_COUNT_LOW, 16'ha5c3);
        check("count write", count, 16'ha5c3);
        repeat (3) strobe(4);
        check("count stopped", count, 16'ha5c3);
        cpu.write_byte(ADDR_COUNT_HIGH, 8'h77);
        check("high write", count, 16'ha5c3);
        cpu.read_word(ADDR_COUNT_LOW, w);
        check("count read", w, 16'ha5c3);
        cpu.write_byte(ADDR_COUNT_HIGH, 8'h77);
        cpu.read_byte(ADDR_COUNT_HIGH, b);
        check("high read", {8'h00, b}, 16'h0077);
    endtask : t_stopped
    task automatic t_count;
        @(posedge clk);
        cs <= 3'h1;
        oie <= 1'b1;
        cpu.write_word(ADDR_COUNT_LOW, 16'h00fe);
        repeat (3) strobe(4);
        check("prescale count", count, 16'h0101);
        @(posedge clk);
        cs <= 3'h6;
        repeat (2) strobe(4);
        repeat (2) strobe(5);
        check("external count", count, 16'h0103);
        @(posedge clk);
        cs <= 3'h1;
        psc <= 1'b1;
        cpu.write_word(ADDR_COUNT_LOW, 16'h4000);
        check("write wins", count, 16'h4000);
        @(posedge clk);
        psc <= 1'b0;
        cpu.write_word(ADDR_COUNT_LOW, COUNT_MAX);
        strobe(4);
        idle(1);
        check("wrap", count, COUNT_BOTTOM);
        check("overflow", {14'h0, oflag, oirq}, 16'h0003);
        strobe(3);
        check("overflow ack", {15'h0, oflag}, 16'h0000);
    endtask : t_count
    task automatic t_capture;
        @(posedge clk);
        psc <= 1'b1;
        cie <= 1'b1;
        pin_to(1'b1);
        wait_flag(20, n);
        c = cap;
        check("capture moment", cap + 16'h0001, count);
        check("capture irq", {15'h0, cirq}, 16'h0001);
        @(posedge clk);
        psc <= 1'b0;
        cs <= CLOCK_STOPPED;
        cpu.read_word(ADDR_CAPTURE_LOW, w);
        check("capture read", w, c);
        strobe(1);
        check("ack clear", {15'h0, cflag}, 16'h0000);
        pin_to(1'b0);
        idle(12);
        check("wrong edge", {15'h0, cflag}, 16'h0000);
        @(posedge clk);
        rise <= 1'b0;
        pin_to(1'b1);
        idle(12);
        strobe(0);
        pin_to(1'b0);
        wait_flag(20, n);
        strobe(0);
        check("falling capture", {15'h0, cflag}, 16'h0000);
        @(posedge clk);
        rise <= 1'b1;
    endtask : t_capture
    task automatic t_filter;
        pin_to(1'b1);
        wait_flag(20, d0);
        pin_to(1'b0);
        @(posedge clk);
        filt <= 1'b1;
        idle(12);
        strobe(0);
        pin_to(1'b1);
        wait_flag(30, d1);
        check("filter delay", 16'(d1 - d0), 16'h0004);
        pin_to(1'b0);
        idle(12);
        strobe(0);
        pin_to(1'b1);
        repeat (2) @(posedge clk);
        pin <= 1'b0;
        idle(16);
        check("glitch", {15'h0, cflag}, 16'h0000);
        @(posedge clk);
        filt <= 1'b0;
        idle(12);
    endtask : t_filter
    task automatic t_source;
        @(posedge clk);
        csel <= 1'b1;
        idle(12);
        strobe(0);
        pin_to(1'b1);
        idle(12);
        check("pin unselected", {15'h0, cflag}, 16'h0000);
        @(posedge clk);
        cmp <= 1'b1;
        wait_flag(20, n);
        @(posedge clk);
        cmp <= 1'b0;
        csel <= 1'b0;
        idle(12);
        strobe(0);
    endtask : t_source
    task automatic t_top;
        c = cap;
        cpu.write_word(ADDR_CAPTURE_LOW, 16'h1111);
        check("capture locked", cap, c);
        @(posedge clk);
        wave <= WAVE_CTC_CAPTURE;
        cpu.write_word(ADDR_CAPTURE_LOW, 16'h8001);
        check("capture top", cap, 16'h8001);
        pin_to(1'b0);
        idle(12);
        pin_to(1'b1);
        idle(12);
        check("detector off", {15'h0, cflag}, 16'h0000);
        cpu.write_byte(ADDR_COUNT_HIGH, 8'h3c);
        cpu.write_byte(ADDR_COUNT_LOW, 8'h11);
        cpu.write_byte(ADDR_CAPTURE_LOW, 8'h22);
        check("reuse count", count, 16'h3c11);
        check("reuse capture", cap, 16'h3c22);
        @(posedge clk);
        wave <= WAVE_NORMAL;
        cpu.write_word(ADDR_COMPARE_A_LOW, 16'h5a6b);
        cpu.write_byte(ADDR_COUNT_HIGH, 8'h99);
        cpu.read_byte(ADDR_COMPARE_A_HIGH, b);
        check("compare high", {8'h00, b}, 16'h005a);
    endtask : t_top
    task automatic t_modes;
        @(posedge clk);
        wave <= WAVE_CTC_COMPARE;
        cs <= 3'h1;
        cpu.write_word(ADDR_COMPARE_A_LOW, 16'h0002);
        cpu.write_word(ADDR_COUNT_LOW, COUNT_BOTTOM);
        repeat (3) strobe(4);
        check("compare top", count, COUNT_BOTTOM);
        check("compare no overflow", {15'h0, oflag}, 16'h0000);
        @(posedge clk);
        wave <= WAVE_FAST_CAPTURE;
        cpu.write_word(ADDR_CAPTURE_LOW, 16'h0002);
        cpu.write_word(ADDR_COUNT_LOW, COUNT_BOTTOM);
        repeat (3) strobe(4);
        check("fast wrap", count, COUNT_BOTTOM);
        check("fast overflow", {15'h0, oflag}, 16'h0001);
        strobe(2);
        check("overflow clear", {15'h0, oflag}, 16'h0000);
        @(posedge clk);
        wave <= WAVE_PWM_CAPTURE_TOP_A;
        cpu.write_word(ADDR_CAPTURE_LOW, 16'h0003);
        cpu.write_word(ADDR_COUNT_LOW, 16'h0001);
        repeat (4) strobe(4);
        check("down count", count, 16'h0001);
        check("no early overflow", {15'h0, oflag}, 16'h0000);
        strobe(4);
        check("bottom count", count, COUNT_BOTTOM);
        check("bottom overflow", {15'h0, oflag}, 16'h0001);
        @(posedge clk);
        wave <= WAVE_NORMAL;
        cs <= CLOCK_STOPPED;
        strobe(2);
    endtask : t_modes
    // ********
    // Main sequence
    // ********
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {psc, ext, filt, csel, pin, cmp, cie, oie, cclr, oclr, cack, oack} = 12'h000;
        rise = 1'b1;
        cs = CLOCK_STOPPED;
        wave = WAVE_NORMAL;
        n_mismatch = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        check("reset count", count, WORD_RESET);
        check("reset flags", {14'h0, cflag, oflag}, 16'h0000);
        t_stopped;
        t_count;
        t_capture;
        t_filter;
        t_source;
        t_top;
        t_modes;
        close_out;
    end
endmodule : tb_timer16_counter_capture
